// File: verilog/dswc_top.sv
// Purpose: Switch control and status register with path drive outputs
// Assumes: Fault code arrives asynchronously from the switch driver
// Notes: Read data valid the cycle after the read strobe
`timescale 1ns/1ps

module dswc_top (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [dswc_pkg::DSWC_AW-1:0] addr_i,
	input wire logic [dswc_pkg::DSWC_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [dswc_pkg::DSWC_DW-1:0] rdata_o,
	input wire logic [1:0] fault_code_i,
	output logic path_one_close_o,
	output logic path_two_close_o,
	output logic irq_o
);
	import dswc_pkg::*;

	// ----------------------------------------
	// Fault input synchroniser
	// ----------------------------------------
	logic [1:0] flt_s1_r;
	logic [1:0] flt_s2_r;
	logic [1:0] flt_q_r;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flt_s1_r <= DSWC_FLT_NONE;
			flt_s2_r <= DSWC_FLT_NONE;
			flt_q_r <= DSWC_FLT_NONE;
		end else begin
			flt_s1_r <= fault_code_i;
			flt_s2_r <= flt_s1_r;
			flt_q_r <= flt_s2_r;
		end
	end

	// ----------------------------------------
	// Fault code view
	// ----------------------------------------
	logic flt_any;
	logic flt_d_r;
	logic flt_rise;

	function automatic logic code_is_fault(input logic [1:0] code);
		return code != DSWC_FLT_NONE;
	endfunction

	assign flt_any = code_is_fault(flt_q_r);

	// ----------------------------------------
	// Fault event
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flt_d_r <= 1'b0;
		end else begin
			flt_d_r <= flt_any;
		end
	end

	// Only a move from no fault to fault raises the event
	assign flt_rise = flt_any && !flt_d_r;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic sw_hit;
	logic stat_hit;
	logic mask_hit;
	logic sw_wr;
	logic sw_rd;
	logic stat_rd;
	logic mask_wr;
	logic mask_rd;

	function automatic logic reg_hit(input logic [DSWC_AW-1:0] addr, input logic [DSWC_AW-1:0] ofs);
		return addr == ofs;
	endfunction

	function automatic logic strobe_hit(input logic strobe, input logic hit);
		return strobe && hit;
	endfunction

	assign sw_hit = reg_hit(addr_i, DSWC_SWITCH_OFS);
	assign stat_hit = reg_hit(addr_i, DSWC_IRQ_STAT_OFS);
	assign mask_hit = reg_hit(addr_i, DSWC_IRQ_MASK_OFS);
	assign sw_wr = strobe_hit(wr_i, sw_hit);
	assign sw_rd = strobe_hit(rd_i, sw_hit);
	// Status is read-only; a write there is dropped
	assign stat_rd = strobe_hit(rd_i, stat_hit);
	assign mask_wr = strobe_hit(wr_i, mask_hit);
	assign mask_rd = strobe_hit(rd_i, mask_hit);

	// ----------------------------------------
	// Switch register
	// ----------------------------------------
	logic path_one_close_r;
	logic path_two_close_r;
	logic path_one_close_nxt;
	logic path_two_close_nxt;

	// Fault and reserved write bits are dropped
	always_comb begin
		path_one_close_nxt = path_one_close_r;
		path_two_close_nxt = path_two_close_r;
		if (sw_wr) begin
			path_one_close_nxt = wdata_i[DSWC_P1_BIT];
			path_two_close_nxt = wdata_i[DSWC_P2_BIT];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			path_one_close_r <= DSWC_SWITCH_RST[DSWC_P1_BIT];
		end else begin
			path_one_close_r <= path_one_close_nxt;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			path_two_close_r <= DSWC_SWITCH_RST[DSWC_P2_BIT];
		end else begin
			path_two_close_r <= path_two_close_nxt;
		end
	end

	// ----------------------------------------
	// Path drive
	// ----------------------------------------
	assign path_one_close_o = path_one_close_r;
	assign path_two_close_o = path_two_close_r;

	function automatic dswc_data_t sw_word(input logic [1:0] flt, input logic p2, input logic p1);
		dswc_data_t w;
		w = '0;
		w[DSWC_FLT_HI:DSWC_FLT_LO] = flt;
		w[DSWC_P2_BIT] = p2;
		w[DSWC_P1_BIT] = p1;
		return w;
	endfunction

	// ----------------------------------------
	// Path change detection
	// ----------------------------------------
	logic p1_d_r;
	logic p2_d_r;
	logic p1_move;
	logic p2_move;

	// Either direction counts as a change
	function automatic logic level_moved(input logic now_v, input logic was_v);
		return now_v ^ was_v;
	endfunction

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			p1_d_r <= 1'b0;
		end else begin
			p1_d_r <= path_one_close_r;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			p2_d_r <= 1'b0;
		end else begin
			p2_d_r <= path_two_close_r;
		end
	end

	assign p1_move = level_moved(path_one_close_r, p1_d_r);
	assign p2_move = level_moved(path_two_close_r, p2_d_r);

	// ----------------------------------------
	// Interrupt mask
	// ----------------------------------------
	logic [DSWC_NEV-1:0] mask_r;
	logic [DSWC_NEV-1:0] mask_nxt;

	// Only the low event bits are kept
	always_comb begin
		mask_nxt = mask_r;
		if (mask_wr) begin
			mask_nxt = wdata_i[DSWC_NEV-1:0];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_r <= DSWC_IRQ_MASK_RST[DSWC_NEV-1:0];
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// ----------------------------------------
	// Interrupt unit
	// ----------------------------------------
	// One carrier bundles events, clear and mask
	dswc_evt_if ev ();
	logic [DSWC_NEV-1:0] ev_set;

	always_comb begin
		ev_set = '0;
		ev_set[DSWC_EV_FAULT] = flt_rise;
		ev_set[DSWC_EV_P1] = p1_move;
		ev_set[DSWC_EV_P2] = p2_move;
	end

	assign ev.set = ev_set;
	// Reading status clears it; a set in that cycle wins
	assign ev.clr = stat_rd;
	assign ev.mask = mask_r;

	dswc_irq u_irq (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ev(ev.sink)
	);

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	assign irq_o = ev.irq;

	// ----------------------------------------
	// Read select
	// ----------------------------------------
	// Address hits never overlap, so the priority is free
	typedef enum logic [1:0] {
		RSEL_NONE,
		RSEL_SW,
		RSEL_STAT,
		RSEL_MASK
	} dswc_rsel_e;

	dswc_rsel_e rsel;

	always_comb begin
		rsel = RSEL_NONE;
		if (sw_rd) begin
			rsel = RSEL_SW;
		end else if (stat_rd) begin
			rsel = RSEL_STAT;
		end else if (mask_rd) begin
			rsel = RSEL_MASK;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [DSWC_DW-1:0] rdata_nxt;

	// Event bits sit at the bottom of the word
	function automatic dswc_data_t evt_word(input logic [DSWC_NEV-1:0] ev_bits);
		dswc_data_t w;
		w = '0;
		w[DSWC_NEV-1:0] = ev_bits;
		return w;
	endfunction

	// Unmapped or idle cycles read as zero
	always_comb begin
		unique case (rsel)
			RSEL_SW: begin
				rdata_nxt = sw_word(flt_q_r, path_two_close_r, path_one_close_r);
			end
			RSEL_STAT: begin
				rdata_nxt = evt_word(ev.stat);
			end
			RSEL_MASK: begin
				rdata_nxt = evt_word(mask_r);
			end
			RSEL_NONE: begin
				rdata_nxt = '0;
			end
		endcase
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= rdata_nxt;
		end
	end
endmodule

// File: inc/dswc_pkg.sv
// Purpose: Constants and types for the dual switch control register block
// Assumes: 8-bit register data on a plain strobe port
// Notes: Interrupt registers sit beside the switch register
package dswc_pkg;
	localparam int DSWC_AW = 8;
	localparam int DSWC_DW = 8;
	localparam logic [7:0] DSWC_SWITCH_OFS = 8'h20;
	localparam logic [7:0] DSWC_IRQ_STAT_OFS = 8'h21;
	localparam logic [7:0] DSWC_IRQ_MASK_OFS = 8'h22;
	localparam logic [7:0] DSWC_SWITCH_RST = 8'h00;
	localparam logic [7:0] DSWC_IRQ_MASK_RST = 8'h00;
	localparam int DSWC_P1_BIT = 0;
	localparam int DSWC_P2_BIT = 1;
	localparam int DSWC_RSV_LO = 2;
	localparam int DSWC_RSV_HI = 5;
	localparam int DSWC_FLT_LO = 6;
	localparam int DSWC_FLT_HI = 7;
	localparam logic [1:0] DSWC_FLT_NONE = 2'h0;
	// Interrupt status bits
	localparam int DSWC_EV_FAULT = 0;
	localparam int DSWC_EV_P1 = 1;
	localparam int DSWC_EV_P2 = 2;
	localparam int DSWC_NEV = 3;
	typedef logic [DSWC_DW-1:0] dswc_data_t;
endpackage

// File: inc/dswc_evt_if.sv
// Purpose: Event carrier between the register block and the interrupt unit
// Assumes: Single clock domain
// Notes: Pulses are one cycle long
`timescale 1ns/1ps
interface dswc_evt_if;
	import dswc_pkg::*;
	logic [DSWC_NEV-1:0] set;
	logic clr;
	logic [DSWC_NEV-1:0] mask;
	logic [DSWC_NEV-1:0] stat;
	logic irq;
	modport src(output set, output clr, output mask, input stat, input irq);
	modport sink(input set, input clr, input mask, output stat, output irq);
endinterface

// File: verilog/dswc_irq.sv
// Purpose: Sticky interrupt status with mask and level output
// Assumes: Clear comes from a read of the status register
// Notes: A set in the clear cycle wins
`timescale 1ns/1ps
module dswc_irq (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	dswc_evt_if.sink ev
);
	import dswc_pkg::*;
	logic [DSWC_NEV-1:0] stat_r;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stat_r <= '0;
		end else if (ev.clr) begin
			stat_r <= ev.set;
		end else begin
			stat_r <= stat_r | ev.set;
		end
	end

	assign ev.stat = stat_r;
	assign ev.irq = |(stat_r & ev.mask);
endmodule

// File: bench/dswc_top_assertions.sv
// Purpose: Port checks for dswc_top
// Assumes: One clock
// Notes: Bound in testbench
`timescale 1ns/1ps
module dswc_chk (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [1:0] fault_code_i,
	input wire logic path_one_close_o,
	input wire logic path_two_close_o,
	input wire logic irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sw_write_a: assert property (wr_i && addr_i == 8'h20 |=>
		{path_two_close_o, path_one_close_o} == $past(wdata_i[1:0])) else $error("path drive");
	path_hold_a: assert property (!(wr_i && addr_i == 8'h20) |=>
		$stable({path_two_close_o, path_one_close_o})) else $error("path moved");
	rd_back_a: assert property (rd_i && addr_i == 8'h20 |=>
		rdata_o[5:0] == {4'h0, path_two_close_o, path_one_close_o}) else $error("readback");
	rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("idle data");
	rd_unmap_a: assert property (rd_i && (addr_i < 8'h20 || addr_i > 8'h22) |=>
		rdata_o == 8'h00) else $error("unmapped");
	rd_fault_a: assert property (rd_i && addr_i == 8'h20 |=>
		rdata_o[7:6] == $past(fault_code_i, 4)) else $error("fault field");
endmodule

// File: bench/testbench.sv
// Purpose: Self-checking bench for dswc_top
// Assumes: 25 MHz clock
// Notes: Fault pin held before reads
`timescale 1ns/1ps
module testbench;
	logic sys_clk_i, rst_i, wr_i, rd_i, p1, p2, irq;
	logic [7:0] addr_i, wdata_i, rdata_o, v, d;
	logic [1:0] flt;
	int failures = 0, checked = 0, cyc = 0;
	dswc_top u_dswc_top (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.fault_code_i(flt), .path_one_close_o(p1), .path_two_close_o(p2), .irq_o(irq));
	initial begin
		sys_clk_i = 0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc > 5000) begin
			failures++;
			stop_test();
		end
	end
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge sys_clk_i) addr_i <= a;
		wdata_i <= x;
		wr_i <= 1;
		@(posedge sys_clk_i) wr_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_i) addr_i <= a;
		rd_i <= 1;
		@(posedge sys_clk_i) rd_i <= 0;
		#1 v = rdata_o;
	endtask
	function automatic logic [7:0] sw_exp(input logic [1:0] f, input logic [7:0] x);
		return {f, 4'h0, x[1:0]};
	endfunction
	task stop_test();
		$display("failures=%0d checked=%0d", failures, checked);
		if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		rst_i = 1;
		{wr_i, rd_i, addr_i, wdata_i, flt} = '0;
		void'($urandom(65919));
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 0;
		rd(8'h20);
		chk(8'h00, v);
		rd(8'h40);
		chk(8'h00, v);
		wr(8'h22, 8'h07);
		wr(8'h20, 8'hc3);
		repeat (3) @(posedge sys_clk_i);
		chk(8'h01, {7'h0, irq});
		rd(8'h21);
		chk(8'h06, v);
		chk(8'h00, {7'h0, irq});
		wr(8'h22, 8'h00);
		wr(8'h20, 8'h00);
		repeat (3) @(posedge sys_clk_i);
		chk(8'h00, {7'h0, irq});
		wr(8'h21, 8'h00);
		rd(8'h21);
		chk(8'h06, v);
		wr(8'h22, 8'h01);
		rd(8'h22);
		chk(8'h01, v);
		@(posedge sys_clk_i) flt <= 2'h3;
		repeat (6) @(posedge sys_clk_i);
		chk(8'h01, {7'h0, irq});
		rd(8'h21);
		chk(8'h01, v);
		wr(8'h22, 8'h00);
		repeat (40) begin
			@(posedge sys_clk_i) flt <= 2'($urandom);
			d = 8'($urandom) & 8'hc3;
			wr(8'h20, d);
			repeat (4) @(posedge sys_clk_i);
			rd(8'h20);
			chk(sw_exp(flt, d), v);
			chk({6'h0, d[1:0]}, {6'h0, p2, p1});
		end
		stop_test();
	end
endmodule
bind dswc_top dswc_chk u_chk (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.fault_code_i, .path_one_close_o, .path_two_close_o, .irq_o);
